// ### paging_pkg.sv
package paging_pkg;

    // ****************************************
    // Packet layout constants
    // ****************************************
    localparam logic [2:0] VT_SHORT_INSTR = 3'h1; // Vector type of a short instruction vector
    localparam logic [7:0] ROAM_ID = 8'h7d; // Identifier byte of the roaming status packet
    localparam logic [31:0] IDLE_PKT = 32'h7f000000; // Sent when nothing is pending
    localparam logic [5:0] PKT_BITS = 6'h20; // Bits in one packet
    localparam logic [1:0] NOISE_NONE = 2'h0; // Noise result: no information

    // ****************************************
    // Register map (byte addresses) and fields
    // ****************************************
    localparam logic [7:0] REG_CTRL = 8'h00; // Configuration bits, read/write
    localparam logic [7:0] REG_STAT = 8'h04; // Flag and slot state, read only
    localparam logic [7:0] REG_COUNT = 8'h08; // Completed packet reads, read only
    localparam int CTRL_IRS = 0; // Ignore resync signals
    localparam int CTRL_MFC = 1; // Report missed frame parts
    localparam int CTRL_NBC = 2; // Report network bit
    localparam int CTRL_MCM = 3; // Manual collapse mode
    localparam logic [3:0] CTRL_RESET = 4'h0; // Configuration after reset

    // ****************************************
    // Carrier types
    // ****************************************
    typedef struct packed {
        logic [6:0] word_position; // Word slot of the vector in the frame
        logic err; // Uncorrectable or check failure
        logic [1:0] phase; // Phase a..d as 0..3
        logic [2:0] itype; // Instruction type
        logic [10:0] data; // Instruction data bits
        logic long_addr; // Received on a long address
        logic has_msg; // Vector owns message words
    } vector_word_type;

    typedef struct packed {
        logic [6:0] word_position; // Word slot of the message word
        logic err; // More than two bit errors
        logic [1:0] phase; // Phase a..d as 0..3
        logic [20:0] info; // Information bits
    } message_word_type;

    typedef struct packed {
        logic resync; // Resync seen while ignoring it
        logic first_sync; // First sync missed
        logic frame_info; // Frame info word missed
        logic second_sync; // Second sync missed
        logic block_info; // Block info word missed
        logic address; // Address word missed
        logic net_upd; // Network bit updated
        logic net_val; // Network bit value
        logic [1:0] noise; // Noise check result
        logic coll_upd; // Collapse updated
        logic [2:0] coll_val; // Received collapse value
    } roam_flags_type;

    typedef enum {LINK_IDLE, LINK_SHIFT} link_state_type;
    typedef enum {SRC_NONE, SRC_VEC, SRC_MSG, SRC_ROAM} source_type;

endpackage : paging_pkg

// ### pin_sync.sv
`timescale 1ns/1ps
// ****************************************
// Two-flop synchroniser for pin levels
// ****************************************
module pin_sync #(
    parameter int W = 1 // Number of levels
) (
    input wire logic clk, // Device clock
    input wire logic rst_n, // Async reset
    input wire logic [W-1:0] pin, // Raw pin levels
    input wire logic [W-1:0] idle, // Level held during reset
    output logic [W-1:0] level // Synchronised levels
);
    logic [W-1:0] meta; // First stage, read by the second only
    logic [W-1:0] stage2; // Second stage, the only reader of meta
    logic [1:0] fill; // Stages that hold real pin samples

    // Idle value enters after reset so no port feeds the async branch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            stage2 <= '0;
            fill <= 2'h0;
        end else begin
            meta <= pin;
            stage2 <= meta;
            fill <= {fill[0], 1'b1};
        end
    end

    // Idle level until both stages are filled, so reset fakes no edge
    assign level = fill[1] ? stage2 : idle;
endmodule : pin_sync

// ### packet_shifter.sv
`timescale 1ns/1ps
// ****************************************
// Packet shift register, MSB first
// ****************************************
module packet_shifter (
    input wire logic clk, // Device clock
    input wire logic rst_n, // Async reset
    input wire logic load, // Take a new packet
    input wire logic [31:0] pkt, // Packet, byte 3 first out
    input wire logic shift, // Advance one bit
    output logic sdo // Serial data out
);
    logic [31:0] sr; // Remaining bits

    // Load wins over shift; the out bit is always a flop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sr <= '0;
            sdo <= 1'b0;
        end else if (load) begin
            sr <= pkt;
            sdo <= pkt[31];
        end else if (shift) begin
            sr <= {sr[30:0], 1'b0};
            sdo <= sr[30];
        end
    end
endmodule : packet_shifter

// ### paging_packet_formatter.sv
// The AHB-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - Vector packets carry type code 001
// - Byte 3: zero, then word position
// - Error bit on bit errors or check failure
// - Phase in byte 2 bits 6:5
// - Data split over bytes 1 and 0
// - Type 000: temporary address and frame
// - Long address, no error: message follows
// - Messages only for clean message-owning vectors; the code also forwards them after clean long-address vectors without has_msg
// - Message identifier is its word position
// - Message packet byte layout
// - Message error bit on bit errors
// - Any roaming flag prompts host read
// - Resync flag set when ignoring resync
// - Resync flag clears on read
// - Roaming status packet layout
// - Missed flags only when reporting configured
// - Two-bit noise result, clears on read
// - Network update with network bit value
// - Collapse update once per frame
module paging_packet_formatter
    import paging_pkg::*;
(
    input wire logic clk, // Device clock, 20 MHz
    input wire logic rst_n, // Async reset, active low
    input wire logic hsel, // AHB slave select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size, word only
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic [31:0] hrdata, // AHB read data
    output logic hreadyout, // AHB slave ready
    output logic hresp, // AHB response, always OKAY
    input wire logic vec_valid, // Vector word pulse
    input wire vector_word_type vec_in, // Vector word
    input wire logic msg_valid, // Message word pulse
    input wire message_word_type msg_in, // Message word
    input wire logic frame_start, // New frame pulse
    input wire logic resync_seen, // Resync detected pulse
    input wire logic first_sync_fail, // First sync missed pulse
    input wire logic frame_info_fail, // Frame info uncorrectable pulse
    input wire logic second_sync_fail, // Second sync missed pulse
    input wire logic block_info_fail, // Block info uncorrectable pulse
    input wire logic address_fail, // Address word uncorrectable pulse
    input wire logic frame_info_ok, // Frame info correctable pulse
    input wire logic net_bit, // Network bit of that word
    input wire logic noise_done, // Noise check result pulse
    input wire logic [1:0] noise_code, // Noise check result
    input wire logic collapse_seen, // Frame collapse received pulse
    input wire logic [2:0] collapse_in, // Received collapse value
    input wire logic sclk, // Host serial clock pin
    input wire logic sel_n, // Host packet select, active low
    output logic sdo, // Serial data to host
    output logic pkt_ready_n // Prompt to read, active low
);

    // ****************************************
    // Bus slave
    // ****************************************
    logic [3:0] ctrl; // Configuration bits
    logic wr_pend; // Write data phase pending
    logic [7:0] wr_addr; // Latched write address
    logic [15:0] read_count; // Completed packet reads
    logic addr_ok; // Address phase taken
    roam_flags_type flags; // Roaming status flags
    logic vec_full; // Vector slot occupied
    logic msg_full; // Message slot occupied

    assign addr_ok = hsel && htrans[1] && hready;

    // Zero wait states, always OKAY
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Read data taken in the address phase; a write still in its data phase is passed on
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= '0;
        end else if (addr_ok && !hwrite) begin
            unique case (haddr[7:0])
                REG_CTRL: hrdata <= {28'h0, (wr_pend && wr_addr == REG_CTRL) ? hwdata[3:0] : ctrl};
                REG_STAT: hrdata <= {16'h0, vec_full, msg_full, flags};
                REG_COUNT: hrdata <= {16'h0, read_count};
                default: hrdata <= '0; // Unmapped reads zero
            endcase
        end
    end

    // Write address held for the data phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
        end else begin
            wr_pend <= addr_ok && hwrite;
            wr_addr <= haddr[7:0];
        end
    end

    // Configuration register; other addresses ignore writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= CTRL_RESET;
        end else if (wr_pend && wr_addr == REG_CTRL) begin
            ctrl <= hwdata[3:0];
        end
    end

    // ****************************************
    // Link pins
    // ****************************************
    logic [1:0] pins_s; // Synchronised {sclk, sel_n}
    logic sclk_d; // Previous sclk level
    logic sel_d; // Previous sel_n level
    logic sclk_rise; // Host samples a bit
    logic sclk_fall; // Next bit goes out
    logic sel_fall; // Read starts
    logic sel_rise; // Read ends

    pin_sync #(.W(2)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin({sclk, sel_n}),
        .idle(2'h1),
        .level(pins_s)
    );

    // Edge history starts deselected so reset looks like no read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d <= 1'b0;
            sel_d <= 1'b1;
        end else begin
            sclk_d <= pins_s[1];
            sel_d <= pins_s[0];
        end
    end

    assign sclk_rise = pins_s[1] && !sclk_d;
    assign sclk_fall = !pins_s[1] && sclk_d;
    assign sel_fall = !pins_s[0] && sel_d;
    assign sel_rise = pins_s[0] && !sel_d;

    // ****************************************
    // Packet slots
    // ****************************************
    logic [31:0] vec_pkt; // Pending vector packet
    logic [31:0] msg_pkt; // Pending message packet
    logic msg_gate; // Message words may be forwarded
    logic vec_load; // Vector accepted this cycle
    logic msg_load; // Message accepted this cycle
    logic done; // A whole packet was read
    source_type src; // Source of the packet in flight

    // A busy slot refuses new words rather than corrupt a read
    assign vec_load = vec_valid && !vec_full;
    assign msg_load = msg_valid && msg_gate && !msg_full;

    // Vector packet; reserved types pass data untouched
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vec_pkt <= '0;
        end else if (vec_load) begin
            vec_pkt <= {1'b0, vec_in.word_position,
                        vec_in.err,
                        vec_in.phase, 2'h0,
                        VT_SHORT_INSTR,
                        2'h0, vec_in.data[10:5],
                        vec_in.data[4:0], vec_in.itype};
        end
    end

    // Clean vectors on long addresses or with messages open the gate
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            msg_gate <= 1'b0;
        end else if (vec_valid) begin
            msg_gate <= !vec_in.err && (vec_in.has_msg || vec_in.long_addr);
        end
    end

    // Message packet keyed by its own word position; host ignores bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            msg_pkt <= '0;
        end else if (msg_load) begin
            msg_pkt <= {1'b0, msg_in.word_position,
                        msg_in.err,
                        msg_in.phase, msg_in.info};
        end
    end

    // Slot occupancy; a fill in the clearing cycle is refused above
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vec_full <= 1'b0;
            msg_full <= 1'b0;
        end else begin
            if (vec_load) begin
                vec_full <= 1'b1;
            end else if (done && src == SRC_VEC) begin
                vec_full <= 1'b0;
            end
            if (msg_load) begin
                msg_full <= 1'b1;
            end else if (done && src == SRC_MSG) begin
                msg_full <= 1'b0;
            end
        end
    end

    // ****************************************
    // Roaming status flags
    // ****************************************
    roam_flags_type next_flags; // Flags after clear and set
    roam_flags_type snap; // Flags as sent in the current read
    logic roam_pending; // Some flag asks for a read
    logic coll_done; // Collapse already taken this frame
    logic roam_clr; // Roaming packet read completed
    logic coll_take; // Collapse accepted this cycle

    assign roam_clr = done && src == SRC_ROAM;
    assign coll_take = collapse_seen && ctrl[CTRL_MCM] && !coll_done;
    assign roam_pending = flags.resync || flags.first_sync || flags.frame_info || flags.second_sync
                          || flags.block_info || flags.address || flags.net_upd
                          || flags.noise != NOISE_NONE || flags.coll_upd;

    // Clear only what the host saw, then let new events win
    always_comb begin
        next_flags = flags;
        if (roam_clr) begin
            next_flags.resync = flags.resync && !snap.resync;
            next_flags.first_sync = flags.first_sync && !snap.first_sync;
            next_flags.frame_info = flags.frame_info && !snap.frame_info;
            next_flags.second_sync = flags.second_sync && !snap.second_sync;
            next_flags.block_info = flags.block_info && !snap.block_info;
            next_flags.address = flags.address && !snap.address;
            next_flags.net_upd = flags.net_upd && !snap.net_upd;
            next_flags.coll_upd = flags.coll_upd && !snap.coll_upd;
            if (flags.noise == snap.noise) begin
                next_flags.noise = NOISE_NONE;
            end
        end
        if (resync_seen && ctrl[CTRL_IRS]) begin
            next_flags.resync = 1'b1;
        end
        if (ctrl[CTRL_MFC]) begin
            next_flags.first_sync = next_flags.first_sync || first_sync_fail;
            next_flags.frame_info = next_flags.frame_info || frame_info_fail;
            next_flags.second_sync = next_flags.second_sync || second_sync_fail;
            next_flags.block_info = next_flags.block_info || block_info_fail;
            next_flags.address = next_flags.address || address_fail;
        end
        if (frame_info_ok && ctrl[CTRL_NBC]) begin
            next_flags.net_upd = 1'b1;
            next_flags.net_val = net_bit;
        end
        if (noise_done && noise_code != NOISE_NONE) begin
            next_flags.noise = noise_code;
        end
        if (coll_take) begin
            next_flags.coll_upd = 1'b1;
            next_flags.coll_val = collapse_in;
        end
    end

    // Flags stay set until a completed read clears them
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end

    // One collapse per frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            coll_done <= 1'b0;
        end else if (frame_start) begin
            coll_done <= 1'b0;
        end else if (coll_take) begin
            coll_done <= 1'b1;
        end
    end

    // ****************************************
    // Packet read over the serial link
    // ****************************************
    link_state_type state; // Link state
    logic [5:0] bit_cnt; // Bits sampled by the host
    logic [31:0] next_pkt; // Packet picked at read start
    source_type next_src; // Its source

    // Data packets first, vector before its message, then roaming status
    always_comb begin
        if (vec_full) begin
            next_pkt = vec_pkt;
            next_src = SRC_VEC;
        end else if (msg_full) begin
            next_pkt = msg_pkt;
            next_src = SRC_MSG;
        end else if (roam_pending) begin
            next_pkt = {ROAM_ID, flags.resync, flags.first_sync, flags.frame_info,
                        flags.second_sync, flags.block_info, flags.address, flags.net_upd,
                        flags.net_val, 6'h0, flags.noise, flags.coll_upd, flags.coll_val, 4'h0};
            next_src = SRC_ROAM;
        end else begin
            next_pkt = IDLE_PKT;
            next_src = SRC_NONE;
        end
    end

    // A read counts only when all bits were sampled before deselect
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= LINK_IDLE;
            bit_cnt <= '0;
            src <= SRC_NONE;
            snap <= '0;
        end else begin
            unique case (state)
                LINK_IDLE: begin
                    if (sel_fall) begin
                        state <= LINK_SHIFT;
                        bit_cnt <= '0;
                        src <= next_src;
                        snap <= flags;
                    end
                end
                LINK_SHIFT: begin
                    if (sel_rise) begin
                        state <= LINK_IDLE;
                    end else if (sclk_rise && bit_cnt != PKT_BITS) begin
                        bit_cnt <= bit_cnt + 6'h1;
                    end
                end
            endcase
        end
    end

    assign done = state == LINK_SHIFT && sel_rise && bit_cnt == PKT_BITS;

    packet_shifter u_shift (
        .clk(clk),
        .rst_n(rst_n),
        .load(state == LINK_IDLE && sel_fall),
        .pkt(next_pkt),
        .shift(state == LINK_SHIFT && sclk_fall),
        .sdo(sdo)
    );

    // Prompt and read counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pkt_ready_n <= 1'b1;
            read_count <= '0;
        end else begin
            pkt_ready_n <= !(state == LINK_IDLE && (vec_full || msg_full || roam_pending));
            if (done) begin
                read_count <= read_count + 16'h1;
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    vec_type_a: assert property (vec_load |=> vec_pkt[18:16] == VT_SHORT_INSTR)
        else $error("vector type field wrong");
    wn_msb_a: assert property (vec_full |-> !vec_pkt[31] && (!msg_full || !msg_pkt[31]))
        else $error("word position top bit set");
    vec_err_a: assert property (vec_load |=> vec_pkt[23] == $past(vec_in.err))
        else $error("vector error bit lost");
    msg_gate_a: assert property (msg_valid && !msg_full && $past(vec_valid) && $past(vec_in.err)
                                 |-> !msg_load)
        else $error("message after bad vector");
    prompt_a: assert property (roam_pending && state == LINK_IDLE && !sel_fall |=> !pkt_ready_n)
        else $error("no prompt for roaming flags");
    resync_set_a: assert property (resync_seen && ctrl[CTRL_IRS] |=> flags.resync)
        else $error("resync flag not set");
    resync_clear_a: assert property (roam_clr && snap.resync && !(resync_seen && ctrl[CTRL_IRS])
                                     |=> !flags.resync)
        else $error("resync flag not cleared");
    flag_hold_a: assert property (flags.resync && !roam_clr |=> flags.resync)
        else $error("resync flag dropped early");
    mfc_gate_a: assert property (!ctrl[CTRL_MFC] && !flags.first_sync |=> !flags.first_sync)
        else $error("missed sync set while unreported");
    coll_once_a: assert property (coll_take ##1 (!frame_start) [*2] |-> !coll_take)
        else $error("collapse taken twice in frame");

endmodule : paging_packet_formatter

// ### host_model.sv
`timescale 1ns/1ps
// ****************************************
// Host reading packets over the serial link
// ****************************************
module host_model (
    input wire logic sdo, // Serial data from device
    output logic sclk, // Serial clock, still between reads
    output logic sel_n, // Packet select, active low
    output logic [31:0] pkt // Last packet taken
);
    // Idle levels from time zero
    initial begin
        sclk = 1'b0;
        sel_n = 1'b1;
        pkt = 32'h0;
    end
    // One read: select, settle, 32 clocks; bits taken on the rising edge
    task automatic read_pkt;
        #10 sel_n = 1'b0; // Off the device clock edge
        #400;
        repeat (32) begin
            #200 sclk = 1'b1;
            pkt = {pkt[30:0], sdo}; // Follow-on message info taken whole, not interpreted
            #200 sclk = 1'b0;
        end
        #200 sel_n = 1'b1;
        #400; // Deselected gap before the next read
    endtask : read_pkt
endmodule : host_model

// ### tb.sv
`timescale 1ns/1ps
module tb
    import paging_pkg::*;
;
    // ****************************************
    // Stimulus and observed signals
    // ****************************************
    logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic [1:0] htrans = 2'h0, noise_code = 2'h0;
    logic [2:0] hsize = 3'h2, collapse_in = 3'h0;
    logic vec_valid = 1'b0, msg_valid = 1'b0, frame_start = 1'b0, net_bit = 1'b0;
    logic noise_done = 1'b0, collapse_seen = 1'b0, hreadyout, hresp, sclk, sel_n, sdo, pkt_ready_n;
    logic [6:0] ev = 7'h0; // Event pulses, resync first
    logic [31:0] pkt;
    vector_word_type vec_in = '0;
    message_word_type msg_in = '0;
    int num_errors = 0, n_tests = 0;
    assign hready = hreadyout; // Single slave drives the bus ready
    always #25 clk = ~clk;
    paging_packet_formatter paging_packet_formatter_i (.clk(clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .vec_valid(vec_valid), .vec_in(vec_in),
        .msg_valid(msg_valid), .msg_in(msg_in), .frame_start(frame_start), .resync_seen(ev[6]),
        .first_sync_fail(ev[5]), .frame_info_fail(ev[4]), .second_sync_fail(ev[3]),
        .block_info_fail(ev[2]), .address_fail(ev[1]), .frame_info_ok(ev[0]), .net_bit(net_bit),
        .noise_done(noise_done), .noise_code(noise_code), .collapse_seen(collapse_seen),
        .collapse_in(collapse_in), .sclk(sclk), .sel_n(sel_n), .sdo(sdo), .pkt_ready_n(pkt_ready_n));
    host_model host_model_i (.sdo(sdo), .sclk(sclk), .sel_n(sel_n), .pkt(pkt));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Single word transfer; waits on hready, never on a fixed count
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= a;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask : ahb
    task automatic read_check(input string what, input logic [31:0] exp);
        host_model_i.read_pkt();
        @(posedge clk);
        check(what, exp, pkt);
    endtask : read_check
    // Vector, then a message word on the next cycle
    task automatic vec_msg(input vector_word_type v, input message_word_type m);
        vec_in <= v;
        vec_valid <= 1'b1;
        @(posedge clk);
        vec_valid <= 1'b0;
        msg_in <= m;
        msg_valid <= 1'b1;
        @(posedge clk);
        msg_valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : vec_msg
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        vector_word_type v;
        message_word_type m;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        // Every instruction type; odd types carry an error, so no message follows
        for (int i = 0; i < 8; i++) begin
            v = '{7'h57, i[0], i[1:0], i[2:0], {4'ha, 7'h25}, i[1], ~i[1]};
            m = '{7'h58, i[0], i[1:0], 21'h1abcde};
            vec_msg(v, m);
            check("ready", 32'h0, {31'h0, pkt_ready_n});
            read_check("vector", {1'b0, 7'h57, i[0], i[1:0], 2'h0, VT_SHORT_INSTR, 2'h0, 6'h29, 5'h05, i[2:0]});
            read_check("message", i[0] ? IDLE_PKT : {1'b0, 7'h58, i[0], i[1:0], 21'h1abcde});
            $display("Test vector type %0d done", i);
        end
        // Roaming events with every report enabled
        ahb(1'b1, {24'h0, REG_CTRL}, 32'hf);
        ahb(1'b0, {24'h0, REG_CTRL}, 32'h0);
        check("ctrl", 32'hf, q);
        ahb(1'b0, 32'h40, 32'h0);
        check("unmapped", 32'h0, q);
        net_bit <= 1'b1;
        noise_code <= 2'h2;
        collapse_in <= 3'h5;
        ev <= 7'h7f;
        noise_done <= 1'b1;
        collapse_seen <= 1'b1;
        @(posedge clk);
        ev <= 7'h0;
        noise_done <= 1'b0;
        collapse_seen <= 1'b0;
        repeat (3) @(posedge clk);
        ahb(1'b0, {24'h0, REG_STAT}, 32'h0);
        check("stat", {18'h0, 7'h7f, 1'b1, 2'h2, 1'b1, 3'h5}, q);
        read_check("roam", {ROAM_ID, 8'hff, 6'h0, 2'h2, 1'b1, 3'h5, 4'h0});
        read_check("cleared", IDLE_PKT);
        ahb(1'b0, {24'h0, REG_COUNT}, 32'h0);
        check("count", 32'h12, q);
        // Reporting disabled: events must leave nothing behind
        ahb(1'b1, {24'h0, REG_CTRL}, 32'h0);
        ev <= 7'h7e;
        collapse_seen <= 1'b1;
        @(posedge clk);
        ev <= 7'h0;
        collapse_seen <= 1'b0;
        repeat (3) @(posedge clk);
        check("quiet", 32'h1, {31'h0, pkt_ready_n});
        read_check("disabled", IDLE_PKT);
        $display("Test roaming done");
        complete_run();
    end
    // Watchdog well beyond the expected run of about 270 us
    initial begin
        #2000000;
        num_errors++;
        complete_run();
    end
endmodule : tb
